// ==== rtl/tpl_pkg.sv ====
// Purpose: Shared constants and types of the touch probe position latch.
// Assumes: Object indices are the 16-bit indices that the controller uses.
// Notes: One control byte and one status byte per channel.
package tpl_pkg;

   // ---------------------------------------------------------------
   // Object indices
   // ---------------------------------------------------------------
   localparam logic [15:0] TPL_IDX_CONTROL = 16'h60b8;
   localparam logic [15:0] TPL_IDX_STATUS = 16'h60b9;
   localparam logic [15:0] TPL_IDX_POS_ONE = 16'h60ba;
   localparam logic [15:0] TPL_IDX_POS_TWO = 16'h60bc;

   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam int TPL_CH_ONE_LSB = 0;
   localparam int TPL_CH_TWO_LSB = 8;
   localparam int TPL_BIT_ENABLE = 0;
   localparam int TPL_BIT_CONT = 1;
   localparam int TPL_BIT_SRC = 2;
   localparam int TPL_BIT_POS_EDGE = 4;
   localparam logic [15:0] TPL_CONTROL_RST = 16'h0000;
   localparam logic [7:0] TPL_STATUS_RST = 8'h00;
   localparam logic [31:0] TPL_POS_RST = 32'h0000_0000;

   // Control byte of one channel, bit 0 at the bottom.
   typedef struct packed {
      logic [1:0] spare_hi;
      logic edge_neg;
      logic edge_pos;
      logic spare_lo;
      logic src_index;
      logic continuous;
      logic enable;
   } tpl_chan_ctrl_type;

   // Status byte of one channel, bit 0 at the bottom.
   typedef struct packed {
      logic [4:0] spare;
      logic neg_done;
      logic pos_done;
      logic enabled;
   } tpl_chan_stat_type;

   typedef struct packed {
      logic prev;
      tpl_chan_stat_type status;
      logic [31:0] pos;
   } tpl_chan_state_type;

   typedef struct packed {
      logic [15:0] ctrl;
      logic [31:0] rdata;
      logic ack;
   } tpl_top_state_type;

endpackage

// ==== rtl/tpl_channel.sv ====
// Purpose: One latch channel: edge detection, arming and position capture.
// Assumes: Trigger, index and position are synchronous to ref_clk.
// Notes: ALLOW_INDEX lets the control byte pick the encoder index pulse.
`timescale 1ns/100ps
module tpl_channel
   import tpl_pkg::*;
#(
   parameter bit ALLOW_INDEX = 1'b0
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire tpl_chan_ctrl_type ctrl,
   input wire logic trig_in,
   input wire logic index_in,
   input wire logic [31:0] position,
   output tpl_chan_stat_type status_q,
   output logic [31:0] capture_q
);

   tpl_chan_state_type st_q;
   tpl_chan_state_type st_d;
   logic trig;
   logic rise;
   logic fall;
   logic take_rise;
   logic take_fall;

   // ---------------------------------------------------------------
   // Trigger selection and capture
   // ---------------------------------------------------------------
   // Only the first channel may choose the index pulse.
   assign trig = (ALLOW_INDEX && ctrl.src_index) ?
      index_in : trig_in;
   assign rise = trig & ~st_q.prev;
   assign fall = ~trig & st_q.prev;
   // Single mode takes one event per edge until rearmed.
   assign take_rise = ctrl.enable && ctrl.edge_pos && rise &&
      (ctrl.continuous || !st_q.status.pos_done);
   assign take_fall = ctrl.enable && ctrl.edge_neg && fall &&
      (ctrl.continuous || !st_q.status.neg_done);

   always_comb begin
      st_d = st_q;
      st_d.prev = trig;
      if (!ctrl.enable) begin
         st_d.status = TPL_STATUS_RST;
      end else begin
         st_d.status.enabled = 1'b1;
         // Dropping an edge enable rearms that edge for single mode.
         if (!ctrl.edge_pos) begin
            st_d.status.pos_done = 1'b0;
         end
         if (!ctrl.edge_neg) begin
            st_d.status.neg_done = 1'b0;
         end
         if (take_rise) begin
            st_d.status.pos_done = 1'b1;
            st_d.pos = position;
         end
         if (take_fall) begin
            st_d.status.neg_done = 1'b1;
            st_d.pos = position;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         st_q <= '{prev: 1'b0, status: TPL_STATUS_RST, pos: TPL_POS_RST};
      end else begin
         st_q <= st_d;
      end
   end

   assign status_q = st_q.status;
   assign capture_q = st_q.pos;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   sequence s_armed_rise;
      ctrl.enable && ctrl.edge_pos && rise && !st_q.status.pos_done;
   endsequence

   sequence s_armed_fall;
      ctrl.enable && ctrl.edge_neg && fall && !st_q.status.neg_done;
   endsequence

   a_capture_on_edge: assert property (
      s_armed_rise |=> capture_q == $past(position) && status_q.pos_done)
      else $error("armed rising edge did not capture position");
   a_single_holds: assert property (
      ctrl.enable && !ctrl.continuous && ctrl.edge_pos && !ctrl.edge_neg &&
      status_q.pos_done && $stable(ctrl) |=> $stable(capture_q))
      else $error("single mode recaptured without rearm");
   a_disabled_clear: assert property (
      !ctrl.enable |=> status_q == TPL_STATUS_RST)
      else $error("disabled channel shows status");
   a_no_spurious: assert property (
      !(take_rise || take_fall) |=> $stable(capture_q))
      else $error("capture changed without trigger");
   a_capture_on_fall: assert property (
      s_armed_fall |=> capture_q == $past(position) && status_q.neg_done)
      else $error("armed falling edge did not capture position");
   a_cont_recapture: assert property (
      ctrl.enable && ctrl.continuous && ctrl.edge_pos && rise
      |=> capture_q == $past(position) && status_q.pos_done)
      else $error("continuous mode missed a rising edge");

endmodule

// ==== rtl/tpl_latch.sv ====
// Purpose: Two-channel touch probe position latch with object access port.
// Assumes: Controller accesses are one-cycle strobes on ref_clk.
// Notes: Read data and acknowledge come one cycle after the strobe.
`timescale 1ns/100ps
module tpl_latch
   import tpl_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [15:0] obj_index,
   input wire logic obj_wr,
   input wire logic [31:0] obj_wdata,
   input wire logic obj_rd,
   output logic [31:0] obj_rdata_q,
   output logic obj_ack_q,
   input wire logic probe_one_trigger_input,
   input wire logic probe_two_trigger_input,
   input wire logic encoder_index_pulse,
   input wire logic [31:0] actual_position,
   input wire logic homing_active
);

   tpl_top_state_type st_q;
   tpl_top_state_type st_d;
   tpl_chan_stat_type stat_one;
   tpl_chan_stat_type stat_two;
   logic [31:0] cap_one;
   logic [31:0] cap_two;
   logic [15:0] status_word;
   logic [15:0] wr_word;

   // ---------------------------------------------------------------
   // Channels
   // ---------------------------------------------------------------
   // Separate instances keep the two channels from blocking each other.
   tpl_channel #(.ALLOW_INDEX(1'b1)) u_chan_one (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .ctrl(tpl_chan_ctrl_type'(st_q.ctrl[7:0])),
      .trig_in(probe_one_trigger_input),
      .index_in(encoder_index_pulse),
      .position(actual_position),
      .status_q(stat_one),
      .capture_q(cap_one)
   );

   tpl_channel #(.ALLOW_INDEX(1'b0)) u_chan_two (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .ctrl(tpl_chan_ctrl_type'(st_q.ctrl[15:8])),
      .trig_in(probe_two_trigger_input),
      .index_in(1'b0),
      .position(actual_position),
      .status_q(stat_two),
      .capture_q(cap_two)
   );

   assign status_word = {stat_two, stat_one};

   // ---------------------------------------------------------------
   // Object access
   // ---------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      st_d.ack = obj_rd;
      wr_word = obj_wdata[15:0];
      // A set rising-edge enable pins the source bit of its channel.
      if (st_q.ctrl[TPL_CH_ONE_LSB + TPL_BIT_POS_EDGE]) begin
         wr_word[TPL_CH_ONE_LSB + TPL_BIT_SRC] =
            st_q.ctrl[TPL_CH_ONE_LSB + TPL_BIT_SRC];
      end
      if (st_q.ctrl[TPL_CH_TWO_LSB + TPL_BIT_POS_EDGE]) begin
         wr_word[TPL_CH_TWO_LSB + TPL_BIT_SRC] =
            st_q.ctrl[TPL_CH_TWO_LSB + TPL_BIT_SRC];
      end
      if (obj_wr && obj_index == TPL_IDX_CONTROL) begin
         st_d.ctrl = wr_word;
      end
      // Homing wins over any write that would enable channel one.
      if (homing_active) begin
         st_d.ctrl[TPL_CH_ONE_LSB + TPL_BIT_ENABLE] = 1'b0;
      end
      // Read data holds between reads; an unmapped index answers zero.
      if (!obj_rd) begin
         st_d.rdata = st_q.rdata;
      end else if (obj_index == TPL_IDX_CONTROL) begin
         st_d.rdata = {16'h0000, st_q.ctrl};
      end else if (obj_index == TPL_IDX_STATUS) begin
         st_d.rdata = {16'h0000, status_word};
      end else if (obj_index == TPL_IDX_POS_ONE) begin
         st_d.rdata = cap_one;
      end else if (obj_index == TPL_IDX_POS_TWO) begin
         st_d.rdata = cap_two;
      end else begin
         st_d.rdata = 32'h0000_0000;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         st_q <= '{ctrl: TPL_CONTROL_RST, rdata: 32'h0000_0000, ack: 1'b0};
      end else begin
         st_q <= st_d;
      end
   end

   assign obj_rdata_q = st_q.rdata;
   assign obj_ack_q = st_q.ack;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   a_homing_off: assert property (
      homing_active |=> !st_q.ctrl[0] ##1 !stat_one.enabled)
      else $error("channel one stayed on during homing");
   a_src_locked: assert property (
      obj_wr && obj_index == TPL_IDX_CONTROL && st_q.ctrl[4]
      |=> st_q.ctrl[2] == $past(st_q.ctrl[2]))
      else $error("source bit changed while edge enabled");
   a_ctrl_high_store: assert property (
      obj_wr && obj_index == TPL_IDX_CONTROL
      |=> st_q.ctrl[15:11] == $past(obj_wdata[15:11]) &&
          st_q.ctrl[9:8] == $past(obj_wdata[9:8]))
      else $error("control high byte not stored");
   a_read_capture: assert property (
      obj_rd && obj_index == TPL_IDX_POS_TWO
      |=> obj_ack_q && obj_rdata_q == $past(cap_two))
      else $error("second position read wrong");
   a_read_status: assert property (
      obj_rd && obj_index == TPL_IDX_STATUS
      |=> obj_rdata_q == {16'h0000, $past(status_word)})
      else $error("status read wrong");

   // ---------------------------------------------------------------
   // Access sequences
   // ---------------------------------------------------------------
   // Every strobe lasts one cycle, so each access is a one-cycle match.
   // Homing is left out of the write sequences because it overrides bit 0.
   sequence s_plain_write;
      obj_wr && obj_index == TPL_IDX_CONTROL && !homing_active;
   endsequence

   sequence s_foreign_write;
      obj_wr && obj_index != TPL_IDX_CONTROL && !homing_active;
   endsequence

   sequence s_unmapped_read;
      obj_rd && obj_index != TPL_IDX_CONTROL &&
      obj_index != TPL_IDX_STATUS && obj_index != TPL_IDX_POS_ONE &&
      obj_index != TPL_IDX_POS_TWO;
   endsequence

   sequence s_answer;
      obj_ack_q;
   endsequence

   // ---------------------------------------------------------------
   // Access checks
   // ---------------------------------------------------------------
   a_read_ack: assert property (
      obj_rd |=> s_answer)
      else $error("read not acknowledged");
   a_ack_pulse: assert property (
      !obj_rd |=> !obj_ack_q)
      else $error("acknowledge without read");
   a_rdata_hold: assert property (
      !obj_rd |=> $stable(obj_rdata_q))
      else $error("read data changed without read");
   a_read_pos_one: assert property (
      obj_rd && obj_index == TPL_IDX_POS_ONE
      |=> obj_ack_q && obj_rdata_q == $past(cap_one))
      else $error("first position read wrong");
   a_read_ctrl: assert property (
      obj_rd && obj_index == TPL_IDX_CONTROL
      |=> obj_rdata_q == {16'h0000, $past(st_q.ctrl)})
      else $error("control read wrong");
   a_unmapped_zero: assert property (
      s_unmapped_read |=> obj_ack_q && obj_rdata_q == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_ctrl_low_store: assert property (
      s_plain_write
      |=> st_q.ctrl[7:3] == $past(obj_wdata[7:3]) &&
          st_q.ctrl[1:0] == $past(obj_wdata[1:0]))
      else $error("control low byte not stored");
   a_foreign_ignored: assert property (
      s_foreign_write |=> $stable(st_q.ctrl))
      else $error("write to another object changed control");
   a_src_two_locked: assert property (
      obj_wr && obj_index == TPL_IDX_CONTROL &&
      st_q.ctrl[TPL_CH_TWO_LSB + TPL_BIT_POS_EDGE]
      |=> st_q.ctrl[TPL_CH_TWO_LSB + TPL_BIT_SRC] ==
          $past(st_q.ctrl[TPL_CH_TWO_LSB + TPL_BIT_SRC]))
      else $error("second source bit changed while edge enabled");
   a_homing_keeps_two: assert property (
      homing_active && !(obj_wr && obj_index == TPL_IDX_CONTROL)
      |=> st_q.ctrl[15:8] == $past(st_q.ctrl[15:8]))
      else $error("homing disturbed channel two");
   a_chan_one_off: assert property (
      !st_q.ctrl[TPL_CH_ONE_LSB + TPL_BIT_ENABLE] |=> !stat_one.enabled)
      else $error("channel one enabled without control bit");
   a_chan_two_off: assert property (
      !st_q.ctrl[TPL_CH_TWO_LSB + TPL_BIT_ENABLE] |=> !stat_two.enabled)
      else $error("channel two enabled without control bit");

endmodule

// ==== dv/tpl_ctrl_model.sv ====
// Purpose: Controller model that reads and writes the latch objects.
// Assumes: One-cycle strobes, answer sampled on falling edges.
// Notes: Index and data lines show inverted junk while no strobe is up.
`timescale 1ns/100ps
module tpl_ctrl_model
   import tpl_pkg::*;
(
   input wire logic ref_clk,
   output logic [15:0] obj_index,
   output logic obj_wr,
   output logic [31:0] obj_wdata,
   output logic obj_rd,
   input wire logic [31:0] obj_rdata_q,
   input wire logic obj_ack_q
);
   initial begin
      obj_index = 16'h0000;
      obj_wr = 1'b0;
      obj_wdata = 32'h0000_0000;
      obj_rd = 1'b0;
   end

   // ---------------------------------------------------------------
   // Object accesses
   // ---------------------------------------------------------------
   // Control bytes go out as one whole word.
   task automatic wr_obj(input logic [15:0] idx, input logic [31:0] d);
      @(negedge ref_clk);
      obj_index = idx;
      obj_wdata = d;
      obj_wr = 1'b1;
      @(negedge ref_clk);
      obj_wr = 1'b0;
      obj_index = ~idx;
      obj_wdata = ~d;
   endtask

   // The answer is awaited for a few cycles only, so a hang shows.
   task automatic rd_obj(input logic [15:0] idx, output logic [31:0] d,
                         output logic ok);
      int n;
      @(negedge ref_clk);
      obj_index = idx;
      obj_rd = 1'b1;
      @(negedge ref_clk);
      obj_rd = 1'b0;
      obj_index = ~idx;
      ok = 1'b0;
      d = 32'h0000_0000;
      for (n = 0; n < 4 && !ok; n++) begin
         if (obj_ack_q === 1'b1) begin
            ok = 1'b1;
            d = obj_rdata_q;
         end else begin
            @(negedge ref_clk);
         end
      end
   endtask
endmodule

// ==== dv/touch_probe_position_latch_test.sv ====
// Purpose: Self-checking bench of the touch probe position latch.
// Assumes: Inputs change on falling edges of ref_clk.
// Notes: Each scenario but t_reset and t_rerun arms, triggers and reads back through objects.
`timescale 1ns/100ps
module touch_probe_position_latch_test;
   import tpl_pkg::*;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [15:0] obj_index;
   logic obj_wr, obj_rd, obj_ack_q;
   logic [31:0] obj_wdata, obj_rdata_q;
   logic in_one = 1'b0;
   logic in_two = 1'b0;
   logic idx_pulse = 1'b0;
   logic homing = 1'b0;
   logic [31:0] pos = 32'h0000_0000;
   int err_total = 0;
   int comparisons = 0;

   always #5 ref_clk = ~ref_clk;

   tpl_ctrl_model u_tpl_ctrl_model (.ref_clk(ref_clk),
      .obj_index(obj_index), .obj_wr(obj_wr), .obj_wdata(obj_wdata),
      .obj_rd(obj_rd), .obj_rdata_q(obj_rdata_q), .obj_ack_q(obj_ack_q));
   tpl_latch u_tpl_latch (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .obj_index(obj_index), .obj_wr(obj_wr), .obj_wdata(obj_wdata),
      .obj_rd(obj_rd), .obj_rdata_q(obj_rdata_q), .obj_ack_q(obj_ack_q),
      .probe_one_trigger_input(in_one), .probe_two_trigger_input(in_two),
      .encoder_index_pulse(idx_pulse), .actual_position(pos),
      .homing_active(homing));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   task automatic wr(input logic [15:0] d);
      u_tpl_ctrl_model.wr_obj(TPL_IDX_CONTROL, {16'h0000, d});
      cyc(2);
   endtask

   task automatic chk_rd(input logic [15:0] idx, input logic [31:0] exp);
      logic [31:0] d;
      logic ok;
      u_tpl_ctrl_model.rd_obj(idx, d, ok);
      comparisons++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("[ERR] %0t no answer to read of %h", $time, idx);
         report_and_stop();
      end
      if (d !== exp) begin
         err_total++;
         $display("[ERR] %0t object %h read %h want %h", $time, idx, d, exp);
      end
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      chk_rd(TPL_IDX_CONTROL, 32'h0000_0000);
      chk_rd(TPL_IDX_STATUS, 32'h0000_0000);
      chk_rd(16'h60bb, 32'h0000_0000);
      chk_rd(TPL_IDX_POS_ONE, 32'h0000_0000);
      chk_rd(TPL_IDX_POS_TWO, 32'h0000_0000);
      $display("test reset done");
   endtask

   task automatic t_single();
      wr(16'h0011);
      pos = 32'h1234_5678;
      in_one = 1'b1;
      cyc(2);
      chk_rd(TPL_IDX_STATUS, 32'h0000_0003);
      chk_rd(TPL_IDX_POS_ONE, 32'h1234_5678);
      in_one = 1'b0;
      cyc(2);
      pos = 32'hfedc_ba98;
      in_one = 1'b1;
      cyc(2);
      chk_rd(TPL_IDX_POS_ONE, 32'h1234_5678);
      in_one = 1'b0;
      wr(16'h0000);
      chk_rd(TPL_IDX_STATUS, 32'h0000_0000);
      $display("test single done");
   endtask

   task automatic t_both();
      wr(16'h1311);
      pos = 32'h0000_0a5c;
      in_one = 1'b1;
      in_two = 1'b1;
      cyc(2);
      chk_rd(TPL_IDX_STATUS, 32'h0000_0303);
      chk_rd(TPL_IDX_POS_TWO, 32'h0000_0a5c);
      chk_rd(TPL_IDX_POS_ONE, 32'h0000_0a5c);
      in_two = 1'b0;
      cyc(2);
      pos = 32'h8000_0001;
      in_two = 1'b1;
      cyc(2);
      chk_rd(TPL_IDX_POS_TWO, 32'h8000_0001);
      chk_rd(TPL_IDX_POS_ONE, 32'h0000_0a5c);
      in_one = 1'b0;
      in_two = 1'b0;
      wr(16'h0000);
      $display("test both done");
   endtask

   task automatic t_index();
      wr(16'h0015);
      pos = 32'h0000_1111;
      in_one = 1'b1;
      cyc(2);
      in_one = 1'b0;
      chk_rd(TPL_IDX_STATUS, 32'h0000_0001);
      pos = 32'h0000_2222;
      idx_pulse = 1'b1;
      cyc(1);
      idx_pulse = 1'b0;
      cyc(1);
      chk_rd(TPL_IDX_POS_ONE, 32'h0000_2222);
      wr(16'h0011);
      chk_rd(TPL_IDX_CONTROL, 32'h0000_0015);
      wr(16'h0000);
      wr(16'h0000);
      $display("test index done");
   endtask

   task automatic t_homing();
      wr(16'h0011);
      homing = 1'b1;
      cyc(2);
      chk_rd(TPL_IDX_STATUS, 32'h0000_0000);
      pos = 32'h0000_3333;
      in_one = 1'b1;
      cyc(2);
      chk_rd(TPL_IDX_POS_ONE, 32'h0000_2222);
      homing = 1'b0;
      in_one = 1'b0;
      $display("test homing done");
   endtask

   task automatic t_falling();
      wr(16'h1523);
      pos = 32'h0000_4444;
      idx_pulse = 1'b1;
      cyc(1);
      idx_pulse = 1'b0;
      cyc(1);
      chk_rd(TPL_IDX_STATUS, 32'h0000_0101);
      pos = 32'h0000_5555;
      in_one = 1'b1;
      in_two = 1'b1;
      cyc(2);
      chk_rd(TPL_IDX_POS_TWO, 32'h0000_5555);
      chk_rd(TPL_IDX_STATUS, 32'h0000_0301);
      pos = 32'h0000_6666;
      in_one = 1'b0;
      cyc(2);
      chk_rd(TPL_IDX_STATUS, 32'h0000_0305);
      chk_rd(TPL_IDX_POS_ONE, 32'h0000_6666);
      in_one = 1'b1;
      cyc(2);
      pos = 32'h0000_7777;
      in_one = 1'b0;
      cyc(2);
      chk_rd(TPL_IDX_POS_ONE, 32'h0000_7777);
      wr(16'h1123);
      u_tpl_ctrl_model.wr_obj(TPL_IDX_POS_ONE, 32'hffff_ffff);
      chk_rd(TPL_IDX_CONTROL, 32'h0000_1523);
      chk_rd(TPL_IDX_POS_ONE, 32'h0000_7777);
      in_two = 1'b0;
      wr(16'h0000);
      chk_rd(TPL_IDX_CONTROL, 32'h0000_0400);
      wr(16'h0000);
      $display("test falling done");
   endtask

   task automatic t_rerun();
      sys_rst = 1'b1;
      cyc(2);
      sys_rst = 1'b0;
      t_reset();
      $display("test rerun done");
   endtask

   initial begin
      cyc(2);
      sys_rst = 1'b0;
      t_reset();
      t_single();
      t_both();
      t_index();
      t_homing();
      t_falling();
      t_rerun();
      report_and_stop();
   end
endmodule
